// >>> logic/two_top.sv
// Timer waveform outputs: frequency, burst pattern, single pulse, pulse train,
// short and long pulse width, and phase-delayed gate pulses from a sync input.
// Assumes sync_i and the register port are synchronous to clk_i.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "two_map.svh"

module two_top import two_pkg::*; #(
  parameter int PAT_DEPTH = 16,
  parameter int SYNC_TO_CYC = `TWO_SYNC_TO_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // Sync input and waveform outputs.
  input wire logic sync_i,
  output logic wave_o,
  output logic busy_o
);

  localparam int IW = $clog2(PAT_DEPTH);

  // All state of the block.
  typedef struct packed {
    two_mode_t mode;
    logic [2:0] cs;
    logic inv;
    two_edge_t edge_sel;
    logic [15:0] carrier;
    logic [PAT_DEPTH-1:0][15:0] pat;
    logic [8:0] pre;
    logic [15:0] cnt;
    logic [15:0] phase;
    logic [15:0] cur;
    logic [15:0] pend;
    logic pend_v;
    logic run;
    logic lvl;
    logic [15:0] pulses;
    logic [IW:0] idx;
    logic [IW:0] len;
    logic [15:0] car_cnt;
    logic car_lvl;
    logic sync_q;
    logic dly_run;
    logic gate_req;
    logic gate_on;
    logic [7:0] gate_div;
    logic [31:0] to_cnt;
    logic to_flag;
    logic busy;
    logic wave;
    logic [31:0] rd_data;
  } two_state_t;

  two_state_t s;
  two_state_t next_s;

  // Tells whether an address falls in the pattern array window.
  function automatic logic is_pat(input logic [7:0] a);
    is_pat = (a >= `TWO_ADDR_PAT_BASE) && (a < `TWO_ADDR_PAT_BASE + 8'(PAT_DEPTH * 4));
  endfunction

  logic tick;
  logic gate_tick;
  logic rise;
  logic fall;
  logic act_edge;
  logic [15:0] cnt_inc;
  logic [15:0] top;
  logic [IW-1:0] pidx;

  // Prescaler tick, gate clock and sync edge detection.
  always_comb begin
    tick = (s.pre == 9'((`TWO_TICK_BASE_CYC << s.cs) - 1));
    gate_tick = (s.gate_div == 8'(`TWO_GATE_BASE_CYC - 1));
    rise = sync_i & ~s.sync_q;
    fall = ~sync_i & s.sync_q;
    act_edge = (s.edge_sel == TWO_EDGE_RISE) ? rise :
               (s.edge_sel == TWO_EDGE_FALL) ? fall : (rise | fall);
    cnt_inc = s.cnt + 16'h0001;
    top = (s.mode == TWO_MODE_PWM_LONG) ? `TWO_LONG_TOP : `TWO_SHORT_TOP;
    pidx = IW'((addr_i - `TWO_ADDR_PAT_BASE) >> 2);
  end

  // Next-state logic for all modes and the register port.
  // The prescaler runs freely but restarts when frequency or pulse-width output starts, and yields one tick every two clocks shifted left by the clock select.
  // Every counter but the prescaler, the gate clock divider and the sync timeout advances only on a tick, so the clock select scales only those alike.
  // The gate clock divider runs on its own and never restarts, so gate pulses sit on a fixed grid.
  // The sync sample is refreshed every clock; an edge is a change against the previous sample.
  // Read data are cleared every cycle, so a read answer stands for exactly one clock.
  //
  // Frequency mode toggles the level every time the counter reaches the applied half period.
  // A period written while the wave runs is parked and loaded as a low half ends, so no
  // half period is ever cut short or stretched by an update.
  //
  // Single-pulse mode holds the asserted level until the counter reaches the duration.
  // Each write reloads the duration and clears the counter, which makes the pulse retriggerable.
  // Because the prescaler is not restarted here, the pulse may be up to one tick short.
  //
  // Pulse-train mode walks a phase of 256 ticks; the first half of each phase is high.
  // The pulse counter drops as each phase wraps, and busy falls with the last wrap only.
  //
  // The two pulse-width modes share one phase counter that wraps at the mode's top value.
  // A new duty value is held pending and loaded as the phase wraps, never in mid-period.
  //
  // Burst-pattern mode steps through the pattern array; even entries carry modulation,
  // odd entries are silent gaps. The modulation restarts high at every entry boundary so
  // that each burst begins with a full half period of the carrier.
  //
  // Gate mode waits for an active sync edge, loads any pending delay, counts the delay
  // in ticks and then requests a gate pulse. The request is served at the next gate clock
  // boundary and the pulse lasts exactly one gate clock period.
  // While an update is pending and no edge comes, a timeout releases the requester; the
  // update stays pending and is still taken at a later edge.
  always_comb begin
    next_s = s;
    next_s.pre = tick ? 9'h000 : s.pre + 9'h001;
    next_s.gate_div = s.gate_div + 8'h01;
    next_s.sync_q = sync_i;
    next_s.rd_data = 32'h0000_0000;

    // Per-tick waveform progress.
    if (tick && s.run) begin
      case (s.mode)
        TWO_MODE_FREQ: begin
          next_s.cnt = cnt_inc;
          if (cnt_inc >= s.cur) begin
            next_s.cnt = 16'h0000;
            next_s.lvl = ~s.lvl;
            if (!s.lvl && s.pend_v) begin
              next_s.cur = s.pend;
              next_s.pend_v = 1'b0;
            end
          end
        end
        TWO_MODE_ONESHOT: begin
          next_s.cnt = cnt_inc;
          if (cnt_inc >= s.cur) begin
            next_s.run = 1'b0;
            next_s.lvl = 1'b0;
          end
        end
        TWO_MODE_TRAIN: begin
          next_s.phase = (s.phase + 16'h0001) & `TWO_SHORT_TOP;
          next_s.lvl = (next_s.phase < `TWO_HALF_SHORT);
          if (s.phase == `TWO_SHORT_TOP) begin
            next_s.pulses = s.pulses - 16'h0001;
            if (s.pulses == 16'h0001) begin
              next_s.run = 1'b0;
              next_s.busy = 1'b0;
              next_s.lvl = 1'b0;
            end
          end
        end
        TWO_MODE_PWM_SHORT, TWO_MODE_PWM_LONG: begin
          next_s.phase = (s.phase == top) ? 16'h0000 : s.phase + 16'h0001;
          if (s.phase == top && s.pend_v) begin
            next_s.cur = s.pend;
            next_s.pend_v = 1'b0;
          end
          next_s.lvl = (next_s.phase < next_s.cur);
        end
        TWO_MODE_IR: begin
          next_s.cnt = cnt_inc;
          next_s.car_cnt = s.car_cnt + 16'h0001;
          if (s.car_cnt + 16'h0001 >= s.carrier) begin
            next_s.car_cnt = 16'h0000;
            next_s.car_lvl = ~s.car_lvl;
          end
          if (cnt_inc >= s.pat[s.idx[IW-1:0]]) begin
            next_s.cnt = 16'h0000;
            next_s.idx = s.idx + 1'b1;
            next_s.car_cnt = 16'h0000;
            next_s.car_lvl = 1'b1;
            if (s.idx + 1'b1 >= s.len) begin
              next_s.run = 1'b0;
              next_s.busy = 1'b0;
            end
          end
          next_s.lvl = next_s.run & ~next_s.idx[0] & next_s.car_lvl;
        end
        TWO_MODE_GATE: begin
          if (s.dly_run) begin
            next_s.cnt = cnt_inc;
            if (cnt_inc > s.cur) begin
              next_s.dly_run = 1'b0;
              next_s.gate_req = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Gate mode: sync edges, pending update and its timeout.
    if (s.mode == TWO_MODE_GATE) begin
      if (gate_tick) begin
        next_s.gate_on = next_s.gate_req;
        next_s.gate_req = 1'b0;
      end
      if (act_edge && (s.run || s.pend_v)) begin
        if (s.pend_v) begin
          next_s.cur = s.pend;
          next_s.pend_v = 1'b0;
          next_s.busy = 1'b0;
          next_s.run = 1'b1;
        end
        next_s.dly_run = 1'b1;
        next_s.cnt = 16'h0000;
      end else if (s.pend_v && s.busy) begin
        next_s.to_cnt = s.to_cnt + 32'h0000_0001;
        if (s.to_cnt >= 32'(SYNC_TO_CYC - 1)) begin
          next_s.busy = 1'b0;
          next_s.to_flag = 1'b1;
        end
      end
    end

    // Register writes.
    if (wr_i) begin
      if (addr_i == `TWO_ADDR_CTRL) begin
        next_s.mode = two_mode_t'(wr_data_i[`TWO_CTRL_MODE_LSB +: 3]);
        next_s.cs = wr_data_i[`TWO_CTRL_CS_LSB +: 3];
        next_s.inv = wr_data_i[`TWO_CTRL_INV_BIT];
        next_s.edge_sel = two_edge_t'(wr_data_i[`TWO_CTRL_EDGE_LSB +: 2]);
        next_s.run = 1'b0;
        next_s.busy = 1'b0;
        next_s.lvl = 1'b0;
        next_s.pend_v = 1'b0;
        next_s.dly_run = 1'b0;
        next_s.gate_req = 1'b0;
        next_s.gate_on = 1'b0;
        next_s.to_flag = 1'b0;
      end else if (addr_i == `TWO_ADDR_VALUE) begin
        case (s.mode)
          TWO_MODE_FREQ, TWO_MODE_PWM_SHORT, TWO_MODE_PWM_LONG: begin
            if ((wr_data_i[15:0] & top) == 16'h0000 && s.mode != TWO_MODE_FREQ ||
                wr_data_i[15:0] == 16'h0000) begin
              next_s.run = 1'b0;
              next_s.lvl = 1'b0;
              next_s.pend_v = 1'b0;
              next_s.cur = 16'h0000;
            end else if (!s.run) begin
              // Restarting the prescaler makes the first half period as long as every later one.
              next_s.pre = 9'h000;
              next_s.run = 1'b1;
              next_s.cur = (s.mode == TWO_MODE_FREQ) ? wr_data_i[15:0] : wr_data_i[15:0] & top;
              next_s.cnt = 16'h0000;
              next_s.phase = 16'h0000;
              next_s.lvl = 1'b1;
            end else begin
              next_s.pend = (s.mode == TWO_MODE_FREQ) ? wr_data_i[15:0] : wr_data_i[15:0] & top;
              next_s.pend_v = 1'b1;
            end
          end
          TWO_MODE_ONESHOT: begin
            next_s.cur = wr_data_i[15:0];
            next_s.cnt = 16'h0000;
            next_s.run = (wr_data_i[15:0] != 16'h0000);
            next_s.lvl = (wr_data_i[15:0] != 16'h0000);
          end
          TWO_MODE_TRAIN: begin
            next_s.pulses = wr_data_i[15:0];
            next_s.run = (wr_data_i[15:0] != 16'h0000);
            next_s.busy = (wr_data_i[15:0] != 16'h0000);
            next_s.phase = 16'h0000;
            next_s.lvl = (wr_data_i[15:0] != 16'h0000);
          end
          TWO_MODE_IR: begin
            next_s.len = wr_data_i[IW:0];
            next_s.idx = '0;
            next_s.cnt = 16'h0000;
            next_s.car_cnt = 16'h0000;
            next_s.car_lvl = 1'b1;
            next_s.run = (wr_data_i[IW:0] != '0);
            next_s.busy = (wr_data_i[IW:0] != '0);
            next_s.lvl = (wr_data_i[IW:0] != '0);
          end
          TWO_MODE_GATE: begin
            next_s.pend = wr_data_i[15:0];
            next_s.pend_v = 1'b1;
            next_s.busy = 1'b1;
            next_s.to_cnt = 32'h0000_0000;
            next_s.to_flag = 1'b0;
          end
          default: begin
          end
        endcase
      end else if (addr_i == `TWO_ADDR_CARRIER) begin
        next_s.carrier = wr_data_i[15:0];
      end else if (is_pat(addr_i)) begin
        next_s.pat[pidx] = wr_data_i[15:0];
      end
    end

    // Register reads; data stand one cycle after the strobe.
    if (rd_i) begin
      if (addr_i == `TWO_ADDR_CTRL) begin
        next_s.rd_data = {23'h00_0000, s.edge_sel, s.inv, s.cs, s.mode};
      end else if (addr_i == `TWO_ADDR_VALUE) begin
        next_s.rd_data = {16'h0000, s.cur};
      end else if (addr_i == `TWO_ADDR_STATUS) begin
        next_s.rd_data = {27'h000_0000, s.to_flag, s.pend_v, s.busy, s.run, s.wave};
      end else if (addr_i == `TWO_ADDR_CARRIER) begin
        next_s.rd_data = {16'h0000, s.carrier};
      end else if (is_pat(addr_i)) begin
        next_s.rd_data = {16'h0000, s.pat[pidx]};
      end else begin
        next_s.rd_data = 32'h0000_0000;
      end
    end

    // Output level with polarity option.
    next_s.wave = s.inv ^ ((s.mode == TWO_MODE_GATE) ? next_s.gate_on : next_s.lvl);
  end

  // State register.
  // Reset clears every field but the carrier, which leaves frequency mode selected with the output at rest.
  // The carrier half period alone resets to one tick so that a burst never stalls on zero.
  // All outputs are taken straight from fields of this register, so none of them glitches.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.carrier <= `TWO_CARRIER_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;
  assign wave_o = s.wave;
  assign busy_o = s.busy;

endmodule // two_top

// >>> shared/two_map.svh
// Register offsets, field positions, reset values and timing counts of the timer waveform outputs.
// Assumes the includer works with an 8-bit byte address and a 200 MHz core clock.
`ifndef TWO_MAP_SVH
`define TWO_MAP_SVH

// Byte offsets of the registers.
`define TWO_ADDR_CTRL 8'h00
`define TWO_ADDR_VALUE 8'h04
`define TWO_ADDR_STATUS 8'h08
`define TWO_ADDR_CARRIER 8'h0C
`define TWO_ADDR_PAT_BASE 8'h40

// Field positions of the control register.
`define TWO_CTRL_MODE_LSB 0
`define TWO_CTRL_CS_LSB 3
`define TWO_CTRL_INV_BIT 6
`define TWO_CTRL_EDGE_LSB 7

// Field positions of the status register.
`define TWO_ST_WAVE_BIT 0
`define TWO_ST_RUN_BIT 1
`define TWO_ST_BUSY_BIT 2
`define TWO_ST_PEND_BIT 3
`define TWO_ST_TO_BIT 4

// Reset value of the modulation half period, in ticks.
`define TWO_CARRIER_RST 16'h0001

// Core clock rate and time figures.
`define TWO_CLK_MHZ 200
`define TWO_TICK_NS 2000
// The tick lasts 2000 ns divided by the clock rate in MHz, which is two core clocks at any rate.
`define TWO_TICK_BASE_CYC (`TWO_TICK_NS / 1000)
`define TWO_GATE_BASE_CYC 256
`define TWO_SYNC_TO_US 10000
`define TWO_SYNC_TO_CYC (`TWO_SYNC_TO_US * `TWO_CLK_MHZ)

// Waveform periods in ticks.
`define TWO_SHORT_TOP 16'h00FF
`define TWO_LONG_TOP 16'hFFFF
`define TWO_HALF_SHORT 16'h0080

`endif

// >>> shared/two_pkg.sv
// Types shared by the timer waveform outputs.
// Assumes nothing beyond a SystemVerilog compiler.
package two_pkg;

  // Output modes selected by the control register.
  typedef enum logic [2:0] {
    TWO_MODE_FREQ,
    TWO_MODE_IR,
    TWO_MODE_ONESHOT,
    TWO_MODE_TRAIN,
    TWO_MODE_PWM_SHORT,
    TWO_MODE_PWM_LONG,
    TWO_MODE_GATE
  } two_mode_t;

  // Active sync edge for the phase-delay gate mode.
  typedef enum logic [1:0] {
    TWO_EDGE_RISE,
    TWO_EDGE_FALL,
    TWO_EDGE_BOTH
  } two_edge_t;

endpackage

// >>> sim/two_sync_source.sv
// Sync source model standing on the far side of the timer outputs.
// Assumes the bench pulses fire_i for one cycle and sets lag_i in clocks.
`timescale 1ns/1ps
module two_sync_source (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control.
  input wire logic fire_i,
  input wire logic [7:0] lag_i,
  // Sync line, a driven level that never floats.
  output logic sync_o
);
  logic [7:0] wait_cnt;
  logic armed;

  // Toggle the line once the lag runs out, so the bench gets prompt or slow edges.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 8'h00;
      armed <= 1'b0;
      sync_o <= 1'b0;
    end else if (fire_i) begin
      wait_cnt <= lag_i;
      armed <= 1'b1;
    end else if (armed && wait_cnt == 8'h00) begin
      armed <= 1'b0;
      sync_o <= ~sync_o;
    end else if (armed) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end
endmodule // two_sync_source

// >>> sim/two_properties.sv
// Checker for the timer waveform outputs, bound to two_top.
// Assumes only the ports of two_top and its single clock.
`timescale 1ns/1ps
`include "two_map.svh"
module two_properties import two_pkg::*; #(
  parameter int PAT_DEPTH = 16,
  parameter int SYNC_TO_CYC = `TWO_SYNC_TO_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  // Sync input and outputs.
  input wire logic sync_i,
  input wire logic wave_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  two_mode_t mode_q;
  logic inv_q;
  logic [8:0] act_cnt;
  logic [31:0] busy_cnt;
  logic ctrl_wr;
  logic val_wr;

  // Decode the two writes that matter here.
  assign ctrl_wr = wr_i && addr_i == `TWO_ADDR_CTRL;
  assign val_wr = wr_i && addr_i == `TWO_ADDR_VALUE;

  // Follow mode and polarity, and time active runs and busy spans.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= TWO_MODE_FREQ;
      inv_q <= 1'b0;
      act_cnt <= 9'h000;
      busy_cnt <= 32'h0000_0000;
    end else begin
      if (ctrl_wr) begin
        mode_q <= two_mode_t'(wr_data_i[2:0]);
        inv_q <= wr_data_i[6];
      end
      act_cnt <= (ctrl_wr || wave_o == inv_q) ? 9'h000 : act_cnt + 9'h001;
      busy_cnt <= busy_o ? busy_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  ctrl_idle_a: assert property (ctrl_wr |-> ##2 wave_o == inv_q)
    else $error("output not at rest level after control write");
  zero_off_a: assert property (val_wr && wr_data_i == 32'h0000_0000 &&
    mode_q inside {TWO_MODE_FREQ, TWO_MODE_PWM_SHORT, TWO_MODE_PWM_LONG} |-> ##2 (wave_o == inv_q) [*4])
    else $error("zero value did not disable the output");
  train_busy_a: assert property (val_wr && wr_data_i[15:0] != 16'h0000 && mode_q == TWO_MODE_TRAIN
    |-> ##[1:2] busy_o) else $error("pulse train not busy");
  train_done_a: assert property ($fell(busy_o) && mode_q == TWO_MODE_TRAIN |-> wave_o == inv_q)
    else $error("pulse train ended in mid pulse");
  gate_width_a: assert property (mode_q == TWO_MODE_GATE |-> act_cnt <= 9'h100)
    else $error("gate pulse longer than one gate period");
  gate_wait_a: assert property (val_wr && mode_q == TWO_MODE_GATE |-> ##[1:2] busy_o)
    else $error("delay update not waiting");
  gate_limit_a: assert property (mode_q == TWO_MODE_GATE |-> busy_cnt <= SYNC_TO_CYC + 8)
    else $error("sync wait too long");
  no_busy_a: assert property ($stable(mode_q) &&
    mode_q inside {TWO_MODE_FREQ, TWO_MODE_ONESHOT, TWO_MODE_PWM_SHORT, TWO_MODE_PWM_LONG} |-> !busy_o)
    else $error("busy in a mode that never holds the requester");
endmodule // two_properties

bind two_top two_properties #(
  .PAT_DEPTH(PAT_DEPTH),
  .SYNC_TO_CYC(SYNC_TO_CYC)
) u_two_properties (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .sync_i(sync_i), .wave_o(wave_o), .busy_o(busy_o)
);

// >>> sim/two_top_test.sv
// Self-checking testbench for the timer waveform outputs.
// Assumes two_top, the sync source model and the checker are compiled first.
`timescale 1ns/1ps
`include "two_map.svh"
module two_top_test;
  logic clk_i, rst_i, wr_i, rd_i, fire, last;
  logic [7:0] addr_i, lag_i;
  logic [31:0] wr_data_i, rd_data_o, d;
  logic sync_i, wave_o, busy_o;
  int errors = 0;
  int comparisons = 0;
  int n, p;

  two_top #(.PAT_DEPTH(16), .SYNC_TO_CYC(200)) u_two_top (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .sync_i(sync_i), .wave_o(wave_o), .busy_o(busy_o));
  two_sync_source u_two_sync_source (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .lag_i(lag_i),
    .sync_o(sync_i));

  // Clock of 5 ns period.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rd_data_o;
  endtask

  task fire_edge(input logic [7:0] lag);
    @(posedge clk_i);
    lag_i <= lag;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task chk_near(input int g, input int e, input int t);
    chk((g >= e - t && g <= e + t) ? e : g, e);
  endtask

  // Waits for the output to reach a level, then counts the cycles it stays there.
  task run(input logic lv, output int c);
    int w;
    w = 0;
    c = 0;
    while (wave_o !== lv && w < 4000) begin
      @(posedge clk_i);
      #1 w++;
    end
    while (wave_o === lv && c < 70000) begin
      @(posedge clk_i);
      #1 c++;
    end
  endtask

  task highs(input int span, output int c);
    c = 0;
    repeat (span) begin
      @(posedge clk_i);
      #1 if (wave_o === 1'b1) c++;
    end
  endtask

  task give_verdict;
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of about 6000 cycles.
  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    {rst_i, wr_i, rd_i, fire, addr_i, lag_i, wr_data_i} = {1'b1, 51'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TWO_ADDR_STATUS, d);
    chk(d, 32'h0000_0000);
    rd(8'h20, d);
    chk(d, 32'h0000_0000);
    $display("reset test done");
    wr(`TWO_ADDR_CTRL, 32'h0000_0008);
    wr(`TWO_ADDR_VALUE, 32'h0000_0004);
    run(1'b1, n);
    chk_near(n, 16, 1);
    wr(`TWO_ADDR_VALUE, 32'h0000_0008);
    run(1'b0, n);
    chk_near(n, 14, 2);
    run(1'b1, n);
    chk_near(n, 32, 1);
    wr(`TWO_ADDR_VALUE, 32'h0000_0000);
    #6 chk(wave_o, 1'b0);
    wr(`TWO_ADDR_CTRL, 32'h0000_0048);
    #6 chk(wave_o, 1'b1);
    $display("frequency test done");
    wr(`TWO_ADDR_CTRL, 32'h0000_0042);
    wr(`TWO_ADDR_VALUE, 32'h0000_000A);
    run(1'b0, n);
    chk_near(n, 20, 2);
    wr(`TWO_ADDR_VALUE, 32'h0000_000A);
    repeat (10) @(posedge clk_i);
    wr(`TWO_ADDR_VALUE, 32'h0000_000A);
    run(1'b0, n);
    chk_near(n, 20, 3);
    $display("single pulse test done");
    wr(`TWO_ADDR_CTRL, 32'h0000_0004);
    wr(`TWO_ADDR_VALUE, 32'h0000_0040);
    highs(512, n);
    chk_near(n, 128, 3);
    $display("pulse width test done");
    wr(`TWO_ADDR_CTRL, 32'h0000_000B);
    wr(`TWO_ADDR_VALUE, 32'h0000_0003);
    chk(busy_o, 1'b1);
    {n, p, last} = 0;
    while (busy_o === 1'b1 && n < 9000) begin
      @(posedge clk_i);
      #1 n++;
      if (wave_o === 1'b1 && last === 1'b0) p++;
      last = wave_o;
    end
    chk(p, 3);
    chk_near(n, 3072, 8);
    $display("pulse train test done");
    wr(`TWO_ADDR_CTRL, 32'h0000_0006);
    wr(`TWO_ADDR_VALUE, 32'h0000_0003);
    chk(busy_o, 1'b1);
    fire_edge(8'h05);
    run(1'b1, n);
    chk(n, 256);
    chk(busy_o, 1'b0);
    fire_edge(8'h28);
    highs(700, n);
    chk(n, 0);
    fire_edge(8'h00);
    run(1'b1, n);
    chk(n, 256);
    wr(`TWO_ADDR_VALUE, 32'h0000_0005);
    repeat (260) @(posedge clk_i);
    rd(`TWO_ADDR_STATUS, d);
    chk({30'h0, d[4], d[2]}, 32'h0000_0002);
    $display("gate test done");
    give_verdict();
  end
endmodule // two_top_test
